// ===== core/olsr_defs.svh
// Offsets, field positions, reset values and counts of the status bank
`ifndef OLSR_DEFS_SVH
`define OLSR_DEFS_SVH
`define OLSR_OFF_SHADOW 8'h4F
`define OLSR_OFF_STAT1 8'h50
`define OLSR_OFF_STAT2 8'h51
`define OLSR_SHADOW_RST_TERM 8'h07
`define OLSR_SHADOW_RST_CENT 8'h47
`define OLSR_RESV_RST 4'h0
`define OLSR_B_SPEED 7
`define OLSR_B_ROLE 6
`define OLSR_B_LOOP 5
`define OLSR_B_LOS 4
`define OLSR_B_DIAG 3
`define OLSR_B_CU 2
`define OLSR_B_OPT 1
`define OLSR_B_PD 0
`define OLSR_B_MULTI 3
`define OLSR_B_ANEG 2
`define OLSR_LOS_RST 1'b0
`define OLSR_CU_RST 1'b1
`define OLSR_MULTI_RST 1'b0
// Synchronised pin vector positions and idle levels
`define OLSR_P_WARM 6
`define OLSR_P_ROLE 5
`define OLSR_P_SD 4
`define OLSR_P_PDN 3
`define OLSR_P_DIAG 2
`define OLSR_P_LOS 1
`define OLSR_P_ANEG 0
`define OLSR_PIN_RST 7'h08
`define OLSR_INIT_CYC 2'h3
// Host controller Wishbone map
`define OLSR_WB_CMD 8'h00
`define OLSR_WB_STAT 8'h04
`define OLSR_WB_IRQ_STAT 8'h08
`define OLSR_WB_IRQ_CLR 8'h0C
`define OLSR_WB_IRQ_EN 8'h10
`define OLSR_CMD_WE 16
`define OLSR_EV_WDONE 0
`define OLSR_EV_RDONE 1
`endif

// ===== core/olsr_pkg.sv
// Types shared by both ends of the status bank link
package olsr_pkg;
    typedef enum logic [1:0] {
        OLSR_DEV_INIT = 2'b01,
        OLSR_DEV_RUN = 2'b10
    } olsr_dev_state_t;
    typedef enum logic [1:0] {
        OLSR_HOST_IDLE = 2'b01,
        OLSR_HOST_REQ = 2'b10
    } olsr_host_state_t;
endpackage

// ===== core/olsr_mgmt_if.sv
// Management register link between host controller and status bank
interface olsr_mgmt_if;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic ack;
    logic [7:0] rdata;
    modport dev (input req, input we, input addr, input wdata, output ack, output rdata);
    modport host (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface

// ===== core/olsr_dev.sv
// Local status register bank with partner status shadow
// Operation
// - Terminal: shadow follows partner while link up
// - Center: first link-up after power-on loads shadow
// - Center: warm reset/power-down retains shadow value
// - Center: tracking resumes after link returns
// - Shadow reset value depends on side
// - Bit 6 reports terminal or center role
// - Bit 5 shows loopback state
// - Bit 4 selects loss-of-signal report method
// - Method bit: host writes center, pin terminal
// - Diag bit: host center, pin terminal
// - Copper-down bit: host center, hardware terminal
// - Bit 1 is inverse of signal detect
// - Bit 0 is inverse of power-down pin
// - Upper four status-two bits stay zero
// - Multi-interface bit: zero terminal, host center
// - Autoneg bit mirrors config in terminal only
// - Partner status uses local status layout
`include "olsr_defs.svh"
module olsr_dev
    import olsr_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    olsr_mgmt_if.dev mgmt,
    input wire logic role_strap_i,
    input wire logic warm_rst_i,
    input wire logic fiber_signal_detect_pin_i,
    input wire logic power_down_pin_n_i,
    input wire logic diag_fail_pin_i,
    input wire logic los_method_pin_i,
    input wire logic copper_autoneg_strap_i,
    input wire logic opt_link_up_i,
    input wire logic [7:0] partner_status_i,
    input wire logic node_speed_i,
    input wire logic loopback_i,
    input wire logic copper_up_i,
    input wire logic aneg_cfg_wr_i,
    input wire logic aneg_cfg_i,
    output logic [7:0] shadow_bits_o,
    output logic los_notify_method_o
);
    if (ADDR_W != 8)
    begin : g_addr_w_check
        $error("olsr_dev: management address must be 8 bits");
    end

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    olsr_dev_state_t state;
    logic [1:0] init_cnt;
    logic [6:0] pin_meta;
    logic [6:0] pin_sync;
    logic terminal_role;
    logic hold;
    logic link_q;
    logic loopback_flag;
    logic diag_result_bit;
    logic copper_down_bit;
    logic multi_interface_bit;
    logic aneg_cfg;
    logic node_speed_bit;
    logic ack;
    logic [7:0] rdata;

    // Pins from outside the clock domain: two flops before any use
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_meta <= `OLSR_PIN_RST;
            pin_sync <= `OLSR_PIN_RST;
        end
        else
        begin
            pin_meta <= {warm_rst_i, role_strap_i, fiber_signal_detect_pin_i,
                power_down_pin_n_i, diag_fail_pin_i, los_method_pin_i,
                copper_autoneg_strap_i};
            pin_sync <= pin_meta;
        end
    end

    wire running = (state == OLSR_DEV_RUN);
    wire warm_ev = pin_sync[`OLSR_P_WARM] | ~pin_sync[`OLSR_P_PDN];
    wire link_rise = opt_link_up_i & ~link_q;
    wire center_role = ~terminal_role;
    wire wr = mgmt.req & mgmt.we & ~ack & running;
    wire wr_stat1 = wr & center_role & hit(mgmt.addr, `OLSR_OFF_STAT1);
    wire wr_stat2 = wr & center_role & hit(mgmt.addr, `OLSR_OFF_STAT2);
    wire optical_absent_bit = ~pin_sync[`OLSR_P_SD];
    wire powered_down_bit = ~pin_sync[`OLSR_P_PDN];
    wire autoneg_capable_bit = terminal_role & aneg_cfg;
    wire [7:0] status_one = {node_speed_bit, terminal_role, loopback_flag,
        los_notify_method_o, diag_result_bit, copper_down_bit,
        optical_absent_bit, powered_down_bit};
    wire [7:0] status_two = {`OLSR_RESV_RST, multi_interface_bit,
        autoneg_capable_bit, 2'b00};
    wire [7:0] rd_val = hit(mgmt.addr, `OLSR_OFF_SHADOW) ? shadow_bits_o :
        hit(mgmt.addr, `OLSR_OFF_STAT1) ? status_one :
        hit(mgmt.addr, `OLSR_OFF_STAT2) ? status_two : 8'h00;
    wire [7:0] shadow_rst = terminal_role ? `OLSR_SHADOW_RST_TERM
        : `OLSR_SHADOW_RST_CENT;

    // Straps are caught once the synchronisers have filled
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state <= OLSR_DEV_INIT;
            init_cnt <= 2'h0;
            terminal_role <= 1'b0;
        end
        else
        begin
            case (state)
                OLSR_DEV_INIT:
                begin
                    init_cnt <= init_cnt + 2'h1;
                    if (init_cnt == `OLSR_INIT_CYC)
                    begin
                        state <= OLSR_DEV_RUN;
                        terminal_role <= pin_sync[`OLSR_P_ROLE];
                    end
                end
                OLSR_DEV_RUN:
                    state <= OLSR_DEV_RUN;
                default:
                    state <= OLSR_DEV_INIT;
            endcase
        end
    end

    // Partner status shadow; the partner byte shares the local layout
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            shadow_bits_o <= `OLSR_SHADOW_RST_CENT;
            hold <= 1'b0;
            link_q <= 1'b0;
        end
        else if (!running)
        begin
            shadow_bits_o <= pin_sync[`OLSR_P_ROLE] ? `OLSR_SHADOW_RST_TERM
                : `OLSR_SHADOW_RST_CENT;
            link_q <= opt_link_up_i;
        end
        else
        begin
            link_q <= opt_link_up_i;
            if (terminal_role)
            begin
                if (warm_ev)
                    shadow_bits_o <= shadow_rst;
                else if (opt_link_up_i)
                    shadow_bits_o <= partner_status_i;
            end
            else if (warm_ev)
                hold <= 1'b1;
            else if (hold)
            begin
                // Retained byte stays visible until the link comes back
                if (link_rise)
                    hold <= 1'b0;
            end
            else if (opt_link_up_i)
                shadow_bits_o <= partner_status_i;
        end
    end

    // Local status bits
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            los_notify_method_o <= `OLSR_LOS_RST;
            diag_result_bit <= 1'b0;
            copper_down_bit <= `OLSR_CU_RST;
            multi_interface_bit <= `OLSR_MULTI_RST;
            aneg_cfg <= 1'b0;
            loopback_flag <= 1'b0;
            node_speed_bit <= 1'b0;
        end
        else if (!running || warm_ev)
        begin
            // Power-down does not keep configuration, so it reinitialises too
            los_notify_method_o <= `OLSR_LOS_RST;
            diag_result_bit <= pin_sync[`OLSR_P_DIAG];
            copper_down_bit <= `OLSR_CU_RST;
            multi_interface_bit <= `OLSR_MULTI_RST;
            aneg_cfg <= pin_sync[`OLSR_P_ANEG];
            loopback_flag <= 1'b0;
            node_speed_bit <= 1'b0;
        end
        else
        begin
            loopback_flag <= loopback_i;
            node_speed_bit <= node_speed_i;
            if (aneg_cfg_wr_i)
                aneg_cfg <= aneg_cfg_i;
            if (terminal_role)
            begin
                los_notify_method_o <= pin_sync[`OLSR_P_LOS];
                diag_result_bit <= pin_sync[`OLSR_P_DIAG];
                copper_down_bit <= ~copper_up_i;
                multi_interface_bit <= 1'b0;
            end
            else
            begin
                if (wr_stat1)
                begin
                    los_notify_method_o <= mgmt.wdata[`OLSR_B_LOS];
                    diag_result_bit <= mgmt.wdata[`OLSR_B_DIAG];
                    copper_down_bit <= mgmt.wdata[`OLSR_B_CU];
                end
                if (wr_stat2)
                    multi_interface_bit <= mgmt.wdata[`OLSR_B_MULTI];
            end
        end
    end

    // One ack pulse per request; the host drops req after seeing it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack <= 1'b0;
            rdata <= 8'h00;
        end
        else
        begin
            ack <= mgmt.req & ~ack & running;
            if (mgmt.req & ~ack & running)
                rdata <= rd_val;
        end
    end

    assign mgmt.ack = ack;
    assign mgmt.rdata = rdata;
endmodule // olsr_dev

// ===== core/olsr_host.sv
// Host controller: Wishbone slave that issues management accesses
`include "olsr_defs.svh"
module olsr_host
    import olsr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    olsr_mgmt_if.host mgmt,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o
);
    olsr_host_state_t state;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata_last;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;

    wire access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // Writes commit at the edge that samples ack, while the master still holds them
    wire wb_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
    wire idle = (state == OLSR_HOST_IDLE);
    // Commands arriving while busy are dropped; software polls busy first
    wire start = wb_wr & idle & (wb_adr_i == `OLSR_WB_CMD) & (&wb_sel_i[2:0]);
    wire done = (state == OLSR_HOST_REQ) & mgmt.ack;
    wire [1:0] ev = {done & ~we, done & we};
    wire [1:0] clr = (wb_wr & (wb_adr_i == `OLSR_WB_IRQ_CLR) & wb_sel_i[0])
        ? wb_dat_i[1:0] : 2'b00;
    wire [1:0] next_irq_stat = (irq_stat & ~clr) | ev;
    wire [31:0] rd_val = (wb_adr_i == `OLSR_WB_CMD) ? {15'h0000, we, wdata, addr} :
        (wb_adr_i == `OLSR_WB_STAT) ? {16'h0000, rdata_last, 7'h00, ~idle} :
        (wb_adr_i == `OLSR_WB_IRQ_STAT) ? {30'h00000000, irq_stat} :
        (wb_adr_i == `OLSR_WB_IRQ_EN) ? {30'h00000000, irq_en} : 32'h00000000;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state <= OLSR_HOST_IDLE;
            req <= 1'b0;
            we <= 1'b0;
            addr <= 8'h00;
            wdata <= 8'h00;
            rdata_last <= 8'h00;
        end
        else
        begin
            case (state)
                OLSR_HOST_IDLE:
                begin
                    if (start)
                    begin
                        addr <= wb_dat_i[7:0];
                        wdata <= wb_dat_i[15:8];
                        we <= wb_dat_i[`OLSR_CMD_WE];
                        req <= 1'b1;
                        state <= OLSR_HOST_REQ;
                    end
                end
                OLSR_HOST_REQ:
                begin
                    if (mgmt.ack)
                    begin
                        req <= 1'b0;
                        if (!we)
                            rdata_last <= mgmt.rdata;
                        state <= OLSR_HOST_IDLE;
                    end
                end
                default:
                begin
                    req <= 1'b0;
                    state <= OLSR_HOST_IDLE;
                end
            endcase
        end
    end

    // A completion in the clearing cycle survives the clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_stat <= 2'b00;
            irq_en <= 2'b00;
            irq_o <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            irq_stat <= next_irq_stat;
            if (wb_wr & (wb_adr_i == `OLSR_WB_IRQ_EN) & wb_sel_i[0])
                irq_en <= wb_dat_i[1:0];
            irq_o <= |(next_irq_stat & irq_en);
            wb_ack_o <= access;
            if (access & ~wb_we_i)
                wb_dat_o <= rd_val;
        end
    end

    assign mgmt.req = req;
    assign mgmt.we = we;
    assign mgmt.addr = addr;
    assign mgmt.wdata = wdata;
endmodule // olsr_host

// ===== tb/olsr_mgmt_props.sv
// Checker of the management link between host controller and status bank
module olsr_mgmt_props
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req,
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic ack,
    input wire logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_pulse; ack |=> !ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
    property p_ack_req; ack |-> req; endproperty
    a_ack_req: assert property (p_ack_req) else $error("ack without request");
    property p_req_hold; req && !ack |=> req && $stable({we, addr, wdata}); endproperty
    a_req_hold: assert property (p_req_hold) else $error("request changed early");
    // Bound covers the init cycles after reset
    property p_answer; req && !ack |-> ##[1:8] ack; endproperty
    a_answer: assert property (p_answer) else $error("request not answered");
    property p_drop; ack |=> !req ##1 !req; endproperty
    a_drop: assert property (p_drop) else $error("request not released");
    property p_rdata_hold; ack |=> $stable(rdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read byte not held");
    property p_resv; ack && !we && addr == 8'h51 |-> rdata[7:4] == 4'h0; endproperty
    a_resv: assert property (p_resv) else $error("reserved bits not zero");
    property p_unmap; ack && !we && addr > 8'h51 |-> rdata == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule // olsr_mgmt_props

// ===== tb/test_oam_local_status_regs.sv
// Self-checking bench joining host controller and status bank
module test_oam_local_status_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic role = 1'b0, wrst = 1'b0, sd = 1'b1, pdn = 1'b1, diag = 1'b0, losm = 1'b0;
    logic aneg = 1'b0, link = 1'b0, speed = 1'b0, loop = 1'b0, cu_up = 1'b0;
    logic acw = 1'b0, acv = 1'b0, cyc = 1'b0, stb = 1'b0, wwe = 1'b0;
    logic [7:0] partner = 8'h00;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [3:0] wsel = 4'hF;
    logic [31:0] wdat = 32'h0;
    logic [31:0] wbq, rdat;
    logic ack, irq, losn;
    logic [7:0] shadow;
    int err_count = 0;
    int n_tests = 0;
    olsr_mgmt_if mgmt_bus();
    olsr_dev olsr_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .mgmt(mgmt_bus),
        .role_strap_i(role), .warm_rst_i(wrst), .fiber_signal_detect_pin_i(sd),
        .power_down_pin_n_i(pdn), .diag_fail_pin_i(diag), .los_method_pin_i(losm),
        .copper_autoneg_strap_i(aneg), .opt_link_up_i(link), .partner_status_i(partner),
        .node_speed_i(speed), .loopback_i(loop), .copper_up_i(cu_up),
        .aneg_cfg_wr_i(acw), .aneg_cfg_i(acv), .shadow_bits_o(shadow),
        .los_notify_method_o(losn));
    olsr_host olsr_host_inst (.clk_i(clk_i), .rst_i(rst_i), .mgmt(mgmt_bus),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wwe), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(wbq), .wb_ack_o(ack), .irq_o(irq));
    olsr_mgmt_props olsr_mgmt_props_inst (.clk_i(clk_i), .rst_i(rst_i),
        .req(mgmt_bus.req), .we(mgmt_bus.we), .addr(mgmt_bus.addr),
        .wdata(mgmt_bus.wdata), .ack(mgmt_bus.ack), .rdata(mgmt_bus.rdata));
    always #5 clk_i = ~clk_i;
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk8(input string name, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic bail();
        err_count++;
        $display("BAD timeout");
        print_verdict();
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        wwe <= w;
        sel <= wsel;
        adr <= a;
        wdat <= d;
        for (i = 0; i < 20 && ack !== 1'b1; i++)
            @(posedge clk_i);
        if (ack !== 1'b1)
            bail();
        rdat = wbq;
        cyc <= 1'b0;
        stb <= 1'b0;
        sel <= 4'h0;
        @(posedge clk_i);
    endtask
    // Busy is polled, so device init time needs no fixed wait
    task automatic mg(input logic w, input logic [7:0] a, input logic [7:0] d);
        int i;
        wb(1'b1, 8'h00, {15'h0, w, d, a});
        for (i = 0; i < 20; i++)
        begin
            wb(1'b0, 8'h04, 32'h0);
            if (rdat[0] === 1'b0)
                break;
        end
        if (rdat[0] !== 1'b0)
            bail();
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        mg(1'b0, a, 8'h00);
        chk8("mgmt read", e, rdat[15:8]);
    endtask
    task automatic wait_sh(input logic [7:0] e);
        int i;
        for (i = 0; i < 20 && shadow !== e; i++)
            @(posedge clk_i);
        chk8("shadow", e, shadow);
    endtask
    task automatic do_reset(input logic r);
        role <= r;
        rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    task automatic t_center_defaults();
        do_reset(1'b0);
        chk8("shadow", 8'h47, shadow);
        rd(8'h50, 8'h04);
        rd(8'h51, 8'h00);
        rd(8'h60, 8'h00);
        chk8("los method", 8'h00, {7'h0, losn});
    endtask
    task automatic t_center_writes();
        wb(1'b1, 8'h10, 32'h3);
        mg(1'b1, 8'h50, 8'hFF);
        chk8("irq", 8'h01, {7'h0, irq});
        rd(8'h50, 8'h1C);
        chk8("los method", 8'h01, {7'h0, losn});
        mg(1'b1, 8'h51, 8'h0F);
        rd(8'h51, 8'h08);
        loop <= 1'b1;
        sd <= 1'b0;
        speed <= 1'b1;
        rd(8'h50, 8'hBE);
        loop <= 1'b0;
        sd <= 1'b1;
        speed <= 1'b0;
        wb(1'b0, 8'h08, 32'h0);
        chk8("irq status", 8'h03, rdat[7:0]);
        wb(1'b1, 8'h0C, 32'h3);
        wb(1'b0, 8'h14, 32'h0);
        chk8("wb unmapped", 8'h00, rdat[7:0]);
        chk8("irq", 8'h00, {7'h0, irq});
        wb(1'b1, 8'h10, 32'h0);
        rd(8'h51, 8'h08);
        chk8("irq masked", 8'h00, {7'h0, irq});
        wsel <= 4'h1;
        wb(1'b1, 8'h00, {15'h0, 1'b1, 8'h00, 8'h50});
        wsel <= 4'hF;
        wb(1'b0, 8'h00, 32'h0);
        chk8("cmd refused", 8'h51, rdat[7:0]);
        rd(8'h50, 8'h1C);
    endtask
    task automatic t_center_shadow();
        partner <= 8'h5A;
        link <= 1'b1;
        wait_sh(8'h5A);
        wrst <= 1'b1;
        repeat (5) @(posedge clk_i);
        partner <= 8'h33;
        repeat (10) @(posedge clk_i);
        chk8("shadow", 8'h5A, shadow);
        wrst <= 1'b0;
        link <= 1'b0;
        repeat (5) @(posedge clk_i);
        chk8("shadow", 8'h5A, shadow);
        partner <= 8'h66;
        link <= 1'b1;
        wait_sh(8'h66);
        partner <= 8'h67;
        wait_sh(8'h67);
        rd(8'h4F, 8'h67);
        pdn <= 1'b0;
        rd(8'h50, 8'h05);
        partner <= 8'h11;
        repeat (10) @(posedge clk_i);
        chk8("shadow", 8'h67, shadow);
        pdn <= 1'b1;
    endtask
    task automatic t_terminal();
        diag <= 1'b1;
        losm <= 1'b1;
        aneg <= 1'b1;
        cu_up <= 1'b1;
        link <= 1'b0;
        do_reset(1'b1);
        wait_sh(8'h07);
        rd(8'h50, 8'h58);
        chk8("los method", 8'h01, {7'h0, losn});
        mg(1'b1, 8'h50, 8'h00);
        rd(8'h50, 8'h58);
        rd(8'h51, 8'h04);
        mg(1'b1, 8'h51, 8'h0F);
        rd(8'h51, 8'h04);
        acv <= 1'b0;
        acw <= 1'b1;
        @(posedge clk_i);
        acw <= 1'b0;
        rd(8'h51, 8'h00);
        diag <= 1'b0;
        cu_up <= 1'b0;
        rd(8'h50, 8'h54);
        partner <= 8'h21;
        link <= 1'b1;
        wait_sh(8'h21);
        partner <= 8'h12;
        wait_sh(8'h12);
        mg(1'b1, 8'h4F, 8'hAA);
        rd(8'h4F, 8'h12);
    endtask
    initial
    begin
        t_center_defaults();
        t_center_writes();
        t_center_shadow();
        t_terminal();
        print_verdict();
    end
endmodule // test_oam_local_status_regs
